// ==== hw/cms_mode_bits.sv ====
// Status-word mode and flag bank with Avalon-MM access and core side hooks
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module cms_mode_bits
	import cms_pkg::*;
(
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// Avalon-MM slave
	input wire logic [3:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Core pipeline events
	input wire logic IRQ_APPROVE_I,
	input wire logic IRQ_RETURN_I,
	input wire logic [15:0] STACK_ST2_I,
	output logic STACK_PUSH_O,
	output logic [15:0] STACK_ST2_O,
	input wire logic BUS_ERROR_I,
	output logic BUS_FAULT_IRQ_FLAG_SET_O,
	// Pipeline mode outputs
	output logic ADDR_MODE_SWITCH_O,
	output logic LONG_OFFSET_NO_PARALLEL_O,
	output logic COEF_PTR_CIRCULAR_O,
	output logic DEBUG_BLOCK_O,
	output logic EMU_HW_EVENT_ENABLE_O,
	output logic EMULATION_WRITE_ENABLE_O,
	output logic ROUNDING_SELECT_O,
	output logic LEGACY_COMPAT_MODE_O,
	// Rounding path
	input wire logic [39:0] ROUND_OPERAND_I,
	input wire logic ROUND_KEEP_CLASS_I,
	output logic [39:0] ROUND_RESULT_O,
	// Cache control
	output logic CACHE_INVALIDATE_O,
	output logic CACHE_ON_O,
	output logic CACHE_LOCK_O,
	output logic PREFETCH_FLUSH_O,
	// Clock output pin
	output logic CLOCK_OUTPUT_PIN_O
);

	typedef struct packed {
		logic [15:0] st2;
		logic [15:0] st3;
		logic [15:0] ctrl;
		logic [31:0] rdata;
		logic ack;
		logic push;
		logic [15:0] pushed;
		logic flush;
		logic fault_irq;
		logic [39:0] rnd;
		cms_cache_state_t cstate;
		logic [4:0] ccount;
		logic [3:0] div;
		logic clk_out;
	} cms_state_t;

	cms_state_t state_reg;
	cms_state_t state_next;
	cms_round_if rif();

	cms_rounder u_rounder (
		.rif(rif.unit)
	);

	assign rif.operand = ROUND_OPERAND_I;
	assign rif.nearest = state_reg.st2[ST2_ROUND_SEL_BIT];
	assign rif.keep_low = state_reg.ctrl[CTRL_LEGACY_BIT] & ROUND_KEEP_CLASS_I;

	logic acc;
	logic wr;
	logic [1:0] op;
	logic [15:0] wval;
	logic clr_start;

	// Apply a plain write, a bit set or a bit clear to a status word
	function automatic logic [15:0] apply_op(input logic [15:0] cur, input logic [1:0] o,
		input logic [15:0] v, input logic [15:0] mask);
		logic [15:0] r;
		r = cur;
		case (o)
			OP_BIT_SET: r = cur | v;
			OP_BIT_CLEAR: r = cur & ~v;
			default: r = v;
		endcase
		return r & mask;
	endfunction

	always_comb
	begin
		state_next = state_reg;
		acc = (AVS_READ_I | AVS_WRITE_I) & ~state_reg.ack;
		wr = AVS_WRITE_I & acc;
		op = state_reg.ctrl[CTRL_OP_LSB +: 2];
		wval = AVS_WRITEDATA_I[15:0];
		clr_start = wr && AVS_ADDRESS_I == OFF_ST3 && op == OP_BIT_SET && wval[ST3_FLUSH_BUSY_BIT];
		state_next.ack = acc;
		state_next.push = 1'b0;
		state_next.flush = 1'b0;
		state_next.fault_irq = 1'b0;
		state_next.rnd = rif.result;

		// Software access; answer lands one cycle after the request is seen
		if (acc)
		begin
			case (AVS_ADDRESS_I)
				OFF_ST2: state_next.rdata = {16'h0000, state_reg.st2};
				OFF_ST3: state_next.rdata = {16'h0000, state_reg.st3};
				OFF_CTRL: state_next.rdata = {16'h0000, state_reg.ctrl};
				default: state_next.rdata = 32'h0000_0000;
			endcase
		end

		if (wr && AVS_ADDRESS_I == OFF_ST2)
		begin
			state_next.st2 = apply_op(state_reg.st2, op, wval, ST2_IMPL_MASK);
			// Every op code other than set or clear behaves as a plain write
			if (op != OP_BIT_SET && op != OP_BIT_CLEAR)
				state_next.st2[ST2_DEBUG_BLOCK_BIT] = state_reg.st2[ST2_DEBUG_BLOCK_BIT];
		end
		if (wr && AVS_ADDRESS_I == OFF_ST3)
		begin
			state_next.st3 = apply_op(state_reg.st3, op, wval, ST3_IMPL_MASK);
			// Software can never set the fault flag; a plain write of zero or a bit clear of one clears it
			state_next.st3[ST3_BUS_FAULT_BIT] = state_reg.st3[ST3_BUS_FAULT_BIT] &
				state_next.st3[ST3_BUS_FAULT_BIT];
			// Clearing starts only by a set; a write of 0 cannot abort it
			state_next.st3[ST3_FLUSH_BUSY_BIT] = state_reg.st3[ST3_FLUSH_BUSY_BIT] |
				clr_start;
			if (state_reg.st3[ST3_CACHE_ON_BIT] && !state_next.st3[ST3_CACHE_ON_BIT])
				state_next.flush = 1'b1;
		end
		if (wr && AVS_ADDRESS_I == OFF_CTRL)
			state_next.ctrl = wval & 16'h0031;

		// Interrupt entry and return take priority over software
		if (IRQ_APPROVE_I)
		begin
			state_next.push = 1'b1;
			state_next.pushed = state_reg.st2;
			state_next.st2[ST2_DEBUG_BLOCK_BIT] = 1'b1;
			state_next.st2[ST2_EMU_WRITE_BIT] = 1'b0;
		end
		else if (IRQ_RETURN_I)
		begin
			state_next.st2[ST2_DEBUG_BLOCK_BIT] = STACK_ST2_I[ST2_DEBUG_BLOCK_BIT];
			state_next.st2[ST2_EMU_WRITE_BIT] = STACK_ST2_I[ST2_EMU_WRITE_BIT];
		end

		// Bus error set wins over a same-cycle clear
		if (BUS_ERROR_I)
		begin
			state_next.st3[ST3_BUS_FAULT_BIT] = 1'b1;
			state_next.fault_irq = 1'b1;
		end

		// Cache clearing sequence
		case (state_reg.cstate)
			CC_IDLE:
			begin
				state_next.ccount = 5'h00;
				if (state_reg.st3[ST3_FLUSH_BUSY_BIT])
					state_next.cstate = CC_CLEAR;
			end
			CC_CLEAR:
			begin
				state_next.ccount = state_reg.ccount + 5'h01;
				if (state_reg.ccount == CACHE_CLR_LAST)
					state_next.cstate = CC_DONE;
			end
			CC_DONE:
			begin
				// A new clear requested in this very cycle wins, so it is not lost
				state_next.st3[ST3_FLUSH_BUSY_BIT] = clr_start;
				state_next.flush = 1'b1;
				state_next.cstate = CC_IDLE;
			end
			default: state_next.cstate = CC_IDLE;
		endcase

		// Clock output divider, parked high when disabled
		if (state_reg.st3[ST3_CLK_OFF_BIT])
		begin
			state_next.div = 4'h0;
			state_next.clk_out = 1'b1;
		end
		else if (state_reg.div == CLOCK_OUTPUT_PIN_HALF)
		begin
			state_next.div = 4'h0;
			state_next.clk_out = ~state_reg.clk_out;
		end
		else
			state_next.div = state_reg.div + 4'h1;
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			state_reg <= '0;
			state_reg.st2 <= ST2_RESET;
			state_reg.st3 <= ST3_RESET;
			state_reg.ctrl <= CTRL_RESET;
			state_reg.cstate <= CC_IDLE;
			state_reg.clk_out <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~state_reg.ack;
	assign AVS_READDATA_O = state_reg.rdata;
	assign STACK_PUSH_O = state_reg.push;
	assign STACK_ST2_O = state_reg.pushed;
	assign BUS_FAULT_IRQ_FLAG_SET_O = state_reg.fault_irq;
	assign ADDR_MODE_SWITCH_O = state_reg.st2[ST2_ADDR_MODE_BIT];
	assign LONG_OFFSET_NO_PARALLEL_O = state_reg.st2[ST2_ADDR_MODE_BIT];
	assign COEF_PTR_CIRCULAR_O = state_reg.st2[ST2_COEF_CIRC_BIT];
	assign DEBUG_BLOCK_O = state_reg.st2[ST2_DEBUG_BLOCK_BIT];
	assign EMU_HW_EVENT_ENABLE_O = ~state_reg.st2[ST2_DEBUG_BLOCK_BIT];
	assign EMULATION_WRITE_ENABLE_O = state_reg.st2[ST2_EMU_WRITE_BIT];
	assign ROUNDING_SELECT_O = state_reg.st2[ST2_ROUND_SEL_BIT];
	assign LEGACY_COMPAT_MODE_O = state_reg.ctrl[CTRL_LEGACY_BIT];
	assign ROUND_RESULT_O = state_reg.rnd;
	assign CACHE_INVALIDATE_O = state_reg.st3[ST3_FLUSH_BUSY_BIT];
	assign CACHE_ON_O = state_reg.st3[ST3_CACHE_ON_BIT];
	assign CACHE_LOCK_O = state_reg.st3[ST3_CACHE_LOCK_BIT];
	assign PREFETCH_FLUSH_O = state_reg.flush;
	assign CLOCK_OUTPUT_PIN_O = state_reg.clk_out;

endmodule // cms_mode_bits

// ==== pkg/cms_pkg.sv ====
// Package with register layout, reset values and constants for the mode/status bit bank
package cms_pkg;

	// Register byte addresses on the Avalon-MM slave
	localparam logic [3:0] OFF_ST2 = 4'h0;
	localparam logic [3:0] OFF_ST3 = 4'h4;
	localparam logic [3:0] OFF_CTRL = 4'h8;
	localparam logic [3:0] OFF_ROUND_IN_LO = 4'hC;

	// Status word two fields
	localparam int ST2_COEF_CIRC_BIT = 8;
	localparam int ST2_ROUND_SEL_BIT = 10;
	localparam int ST2_EMU_WRITE_BIT = 11;
	localparam int ST2_DEBUG_BLOCK_BIT = 12;
	localparam int ST2_ADDR_MODE_BIT = 15;
	localparam logic [15:0] ST2_IMPL_MASK = 16'h9D00;
	localparam logic [15:0] ST2_RESET = 16'h1000;

	// Status word three fields
	localparam int ST3_CLK_OFF_BIT = 2;
	localparam int ST3_BUS_FAULT_BIT = 7;
	localparam int ST3_FLUSH_BUSY_BIT = 13;
	localparam int ST3_CACHE_ON_BIT = 14;
	localparam int ST3_CACHE_LOCK_BIT = 15;
	localparam logic [15:0] ST3_IMPL_MASK = 16'hE084;
	localparam logic [15:0] ST3_RESET = 16'h0000;

	// Control register fields
	localparam int CTRL_LEGACY_BIT = 0;
	localparam int CTRL_OP_LSB = 4;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Write operations applied to a status word
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_BIT_SET = 2'h1;
	localparam logic [1:0] OP_BIT_CLEAR = 2'h2;

	// Rounding constants
	localparam logic [39:0] ROUND_HALF = 40'h00_0000_8000;
	localparam logic [15:0] HALF_LSW = 16'h8000;

	// Cache clear length and clock divider half period
	localparam int CACHE_CLR_CYCLES = 16;
	localparam logic [4:0] CACHE_CLR_LAST = 5'(CACHE_CLR_CYCLES - 1);
	localparam logic [3:0] CLOCK_OUTPUT_PIN_HALF = 4'h1;

	typedef enum logic [1:0] {
		CC_IDLE = 2'b00,
		CC_CLEAR = 2'b01,
		CC_DONE = 2'b11
	} cms_cache_state_t;

endpackage : cms_pkg

// ==== pkg/cms_round_if.sv ====
// Interface carrying an operand and its rounded result to the rounding unit
`timescale 1ns/1ps
interface cms_round_if;
	logic [39:0] operand;
	logic nearest;
	logic keep_low;
	logic [39:0] result;
	modport core (output operand, output nearest, output keep_low, input result);
	modport unit (input operand, input nearest, input keep_low, output result);
endinterface : cms_round_if

// ==== hw/cms_rounder.sv ====
// Rounding unit for the D-unit rnd() qualifier
`timescale 1ns/1ps
module cms_rounder
	import cms_pkg::*;
(
	cms_round_if.unit rif
);
	logic [39:0] sum;
	logic add_half;

	always_comb
	begin
		add_half = 1'b1;
		if (rif.nearest)
		begin
			if (rif.operand[15:0] < HALF_LSW)
				add_half = 1'b0;
			else if (rif.operand[15:0] == HALF_LSW)
				add_half = rif.operand[16];
			else
				add_half = 1'b1;
		end
		sum = add_half ? (rif.operand + ROUND_HALF) : rif.operand;
		if (rif.keep_low)
			rif.result = sum;
		else
			rif.result = {sum[39:16], 16'h0000};
	end
endmodule // cms_rounder

// ==== bench/cms_core_model.sv ====
// Core stack model that keeps the pushed status word two for the return
`timescale 1ns/1ps
module cms_core_model
(
	// Core side
	input wire logic clk_i,
	input wire logic push_i,
	input wire logic [15:0] word_i,
	output logic [15:0] saved_o
);
	// Arbitrary until the first push, as a real stack slot would be
	initial saved_o = 16'hA5A5;
	always @(posedge clk_i)
		if (push_i === 1'h1)
			saved_o <= word_i;
endmodule // cms_core_model

// ==== bench/cms_mode_bits_asserts.sv ====
// Port-level assertions for the mode and status bit bank
`timescale 1ns/1ps
module cms_chk
(
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	// Bus and core events
	input wire logic AVS_WAITREQUEST_O,
	input wire logic IRQ_APPROVE_I,
	input wire logic STACK_PUSH_O,
	input wire logic BUS_ERROR_I,
	input wire logic BUS_FAULT_IRQ_FLAG_SET_O,
	// Mode and cache levels, and the prefetch flush pulse
	input wire logic ADDR_MODE_SWITCH_O,
	input wire logic LONG_OFFSET_NO_PARALLEL_O,
	input wire logic DEBUG_BLOCK_O,
	input wire logic EMU_HW_EVENT_ENABLE_O,
	input wire logic EMULATION_WRITE_ENABLE_O,
	input wire logic CACHE_INVALIDATE_O,
	input wire logic CACHE_ON_O,
	input wire logic PREFETCH_FLUSH_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	one_wait_a: assert property ($rose(AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
		else $error("waitrequest too long");
	mode_pair_a: assert property (LONG_OFFSET_NO_PARALLEL_O == ADDR_MODE_SWITCH_O)
		else $error("long offset flag differs");
	event_mask_a: assert property (EMU_HW_EVENT_ENABLE_O != DEBUG_BLOCK_O)
		else $error("debug events not masked");
	irq_entry_a: assert property (IRQ_APPROVE_I |=> DEBUG_BLOCK_O && STACK_PUSH_O
		&& !EMULATION_WRITE_ENABLE_O) else $error("interrupt entry wrong");
	fault_flag_a: assert property (BUS_ERROR_I |=> BUS_FAULT_IRQ_FLAG_SET_O)
		else $error("fault irq flag missing");
	off_flush_a: assert property ($fell(CACHE_ON_O) |-> ##[0:1] PREFETCH_FLUSH_O)
		else $error("no flush on disable");
	clear_done_a: assert property ($fell(CACHE_INVALIDATE_O) |-> ##[0:1] PREFETCH_FLUSH_O)
		else $error("no flush after clear");
	clear_len_a: assert property ($rose(CACHE_INVALIDATE_O) |->
		##15 CACHE_INVALIDATE_O ##[1:4] !CACHE_INVALIDATE_O) else $error("clear length wrong");
	cover property (IRQ_APPROVE_I);
	cover property (BUS_ERROR_I);
	cover property ($fell(CACHE_INVALIDATE_O));
endmodule // cms_chk
bind cms_mode_bits cms_chk u_chk (.*);

// ==== bench/testbench.sv ====
// Register-level bench for the mode and status bit bank
`timescale 1ns/1ps
module testbench;
	import cms_pkg::*;
	logic MCLK_I = 1'h0, RST_N_I = 1'h0, AVS_READ_I = 1'h0, AVS_WRITE_I = 1'h0;
	logic ROUND_KEEP_CLASS_I = 1'h0;
	logic [2:0] ev = 3'h0;
	logic [3:0] AVS_ADDRESS_I = 4'h0;
	logic [31:0] AVS_WRITEDATA_I = 32'h0, AVS_READDATA_O, rq;
	logic [39:0] ROUND_OPERAND_I = 40'h0, ROUND_RESULT_O;
	logic [15:0] STACK_ST2_I, STACK_ST2_O;
	logic AVS_WAITREQUEST_O, STACK_PUSH_O, BUS_FAULT_IRQ_FLAG_SET_O, ADDR_MODE_SWITCH_O;
	logic LONG_OFFSET_NO_PARALLEL_O, COEF_PTR_CIRCULAR_O, DEBUG_BLOCK_O, EMU_HW_EVENT_ENABLE_O;
	logic EMULATION_WRITE_ENABLE_O, ROUNDING_SELECT_O, LEGACY_COMPAT_MODE_O, CACHE_INVALIDATE_O;
	logic CACHE_ON_O, CACHE_LOCK_O, PREFETCH_FLUSH_O, CLOCK_OUTPUT_PIN_O;
	wire IRQ_APPROVE_I = ev[0];
	wire IRQ_RETURN_I = ev[1];
	wire BUS_ERROR_I = ev[2];
	int n_fail = 0, n_compared = 0, flushes = 0, faults = 0, hi = 0, i;
	cms_mode_bits u_dut (.*);
	cms_core_model u_core (.clk_i(MCLK_I), .push_i(STACK_PUSH_O), .word_i(STACK_ST2_O),
		.saved_o(STACK_ST2_I));
	always #50 MCLK_I = ~MCLK_I;
	// Pulses are counted so a missing or doubled one shows up later
	always @(posedge MCLK_I) if (PREFETCH_FLUSH_O === 1'h1) flushes <= flushes + 1;
	always @(posedge MCLK_I) if (BUS_FAULT_IRQ_FLAG_SET_O === 1'h1) faults <= faults + 1;
	task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic conclude();
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Sampled at the rising edge before the design updates, as a master flop would
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= {16'h0, d};
		AVS_WRITE_I <= w;
		AVS_READ_I <= ~w;
		do
			@(posedge MCLK_I);
		while (AVS_WAITREQUEST_O !== 1'h0);
		rq = AVS_READDATA_O;
		AVS_WRITE_I <= 1'h0;
		AVS_READ_I <= 1'h0;
		@(posedge MCLK_I);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		acc(1'h0, a, 16'h0);
		chk("readdata", rq, {24'h0, e});
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'h1;
		@(posedge MCLK_I);
		ev[k] <= 1'h0;
		@(posedge MCLK_I);
	endtask
	task automatic rnd(input logic [39:0] op, input logic [39:0] e);
		ROUND_OPERAND_I <= op;
		@(posedge MCLK_I);
		@(negedge MCLK_I);
		chk("round", ROUND_RESULT_O, e);
		@(posedge MCLK_I);
	endtask
	initial
	begin
		// The sequence needs about 150 cycles; this leaves ample margin
		repeat (2000) @(posedge MCLK_I);
		n_fail++;
		conclude();
	end
	initial
	begin
		repeat (4) @(posedge MCLK_I);
		RST_N_I <= 1'h1;
		repeat (2) @(posedge MCLK_I);
		rd(OFF_ST2, ST2_RESET);
		rd(OFF_ST3, ST3_RESET);
		for (i = 0; i < 4; i++) @(negedge MCLK_I) hi += int'(CLOCK_OUTPUT_PIN_O);
		chk("clkpin", 40'(hi), 40'h2);
		@(posedge MCLK_I);
		acc(1'h1, OFF_ST2, 16'h0000);
		rd(OFF_ST2, ST2_RESET);
		acc(1'h1, OFF_ST2, 16'hFFFF);
		rd(OFF_ST2, ST2_IMPL_MASK);
		chk("modes", {ADDR_MODE_SWITCH_O, COEF_PTR_CIRCULAR_O, EMULATION_WRITE_ENABLE_O}, 40'h7);
		chk("dbg", {ROUNDING_SELECT_O, DEBUG_BLOCK_O, EMU_HW_EVENT_ENABLE_O}, 40'h6);
		rnd(40'h00_0001_7FFF, 40'h00_0001_0000);
		rnd(40'h00_0001_8001, 40'h00_0002_0000);
		rnd(40'h00_0001_8000, 40'h00_0002_0000);
		rnd(40'h00_0002_8000, 40'h00_0002_0000);
		acc(1'h1, OFF_CTRL, 16'h0020);
		acc(1'h1, OFF_ST2, 16'h1400);
		rd(OFF_ST2, 16'h8900);
		rnd(40'h00_0002_8000, 40'h00_0003_0000);
		rnd(40'hFF_FFFF_8000, 40'h00_0000_0000);
		acc(1'h1, OFF_CTRL, 16'h0021);
		chk("legacy", LEGACY_COMPAT_MODE_O, 40'h1);
		ROUND_KEEP_CLASS_I <= 1'h1;
		rnd(40'h00_0002_9234, 40'h00_0003_1234);
		ROUND_KEEP_CLASS_I <= 1'h0;
		rnd(40'h00_0002_9234, 40'h00_0003_0000);
		pulse(0);
		rd(OFF_ST2, 16'h9100);
		chk("stack", STACK_ST2_I, 40'h8900);
		pulse(1);
		rd(OFF_ST2, 16'h8900);
		chk("dbg", {DEBUG_BLOCK_O, EMU_HW_EVENT_ENABLE_O}, 40'h1);
		acc(1'h1, OFF_CTRL, 16'h0030);
		acc(1'h1, OFF_ST2, 16'h1000);
		rd(OFF_ST2, 16'h0000);
		acc(1'h1, OFF_CTRL, 16'h0000);
		acc(1'h1, OFF_ST3, 16'h0080);
		rd(OFF_ST3, 16'h0000);
		pulse(2);
		rd(OFF_ST3, 16'h0080);
		chk("faultirq", 40'(faults), 40'h1);
		acc(1'h1, OFF_ST3, 16'h0000);
		rd(OFF_ST3, 16'h0000);
		acc(1'h1, 4'h6, 16'hFFFF);
		rd(4'h6, 16'h0000);
		acc(1'h1, OFF_ST3, 16'hC004);
		chk("cache", {CACHE_ON_O, CACHE_LOCK_O, CACHE_INVALIDATE_O}, 40'h6);
		for (i = 0; i < 8; i++) @(negedge MCLK_I) chk("clkpin", CLOCK_OUTPUT_PIN_O, 40'h1);
		@(posedge MCLK_I);
		acc(1'h1, OFF_CTRL, 16'h0010);
		acc(1'h1, OFF_ST3, 16'h2000);
		rd(OFF_ST3, 16'hE004);
		repeat (20) @(posedge MCLK_I);
		rd(OFF_ST3, 16'hC004);
		chk("flush", 40'(flushes), 40'h1);
		acc(1'h1, OFF_CTRL, 16'h0020);
		acc(1'h1, OFF_ST3, 16'h4000);
		repeat (2) @(posedge MCLK_I);
		chk("flush", 40'(flushes), 40'h2);
		chk("cacheon", CACHE_ON_O, 40'h0);
		conclude();
	end
endmodule // testbench
